/* logic/card_power_pkg.sv */
// Constants, types and bit positions shared by the serial control logic of a
// dual-slot card power switch. Assumes a single 100 MHz system clock.
package card_power_pkg;

    // control word
    localparam int unsigned CTRL_WORD_WIDTH = 11;
    localparam logic [10:0] CTRL_WORD_RESET = 11'h000;

    // bit positions in the control word
    localparam int unsigned SLOT_A_PROG_SEL_HI_POS   = 0;
    localparam int unsigned SLOT_A_PROG_SEL_LO_POS   = 1;
    localparam int unsigned SLOT_A_MAIN_SEL_LO_POS   = 2;
    localparam int unsigned SLOT_A_MAIN_SEL_HI_POS   = 3;
    localparam int unsigned SLOT_B_PROG_SEL_HI_POS   = 4;
    localparam int unsigned SLOT_B_PROG_SEL_LO_POS   = 5;
    localparam int unsigned SLOT_B_MAIN_SEL_HI_POS   = 6;
    localparam int unsigned SLOT_B_MAIN_SEL_LO_POS   = 7;
    localparam int unsigned SHUTDOWN_BIT_POS         = 8;
    localparam int unsigned SLOT_A_PROG_LEVEL_POS    = 9;
    localparam int unsigned SLOT_B_PROG_LEVEL_POS    = 10;

    // synchronised status pins, positions in one vector
    localparam int unsigned PIN_SYNC_WIDTH = 11;
    localparam int unsigned PIN_RESET_HI   = 0;
    localparam int unsigned PIN_RESET_N    = 1;
    localparam int unsigned PIN_MODE       = 2;
    localparam int unsigned PIN_STANDBY_N  = 3;
    localparam int unsigned PIN_OC_A_MAIN  = 4;
    localparam int unsigned PIN_OC_A_PROG  = 5;
    localparam int unsigned PIN_OC_B_MAIN  = 6;
    localparam int unsigned PIN_OC_B_PROG  = 7;
    localparam int unsigned PIN_OVERTEMP   = 8;
    localparam int unsigned PIN_SUPPLY_5V  = 9;
    localparam int unsigned PIN_SUPPLY_12V = 10;
    // idle levels: reset_n and standby_n high, supplies present
    localparam logic [10:0] PIN_SYNC_RESET = 11'h60A;

    // serial pin synchroniser reset value: data, clock, latch all low
    localparam logic [2:0]  SERIAL_SYNC_RESET = 3'h0;

    // timing
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned STANDBY_N_OC_TIME_NS  = 10000;
    localparam int unsigned STANDBY_N_OC_CYCLES   =
        (STANDBY_N_OC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // what each output is switched to
    typedef enum logic [2:0] {
        LVL_GND,
        LVL_3V3,
        LVL_5V,
        LVL_12V,
        LVL_HIZ
    } supply_level_t;

endpackage

/* logic/serial_word_if.sv */
// Carrier between the serial shifter and the control core.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps

interface serial_word_if;
    import card_power_pkg::*;

    logic [CTRL_WORD_WIDTH-1:0] word;        // shift register contents
    logic                       latch_pulse; // one cycle per latch rise

    modport shifter
    (
        output word,
        output latch_pulse
    );

    modport control
    (
        input  word,
        input  latch_pulse
    );
endinterface

/* logic/serial_word_shifter.sv */
// Serial data/clock/latch receiver: oversamples the link pins on the
// system clock, shifts data on clock rises and flags latch rises.
// Assumes the link clock is far slower than the system clock.
`timescale 1ns/1ps

module serial_word_shifter
    import card_power_pkg::*;
(
    // clock and reset
    input  wire logic           sys_clk_i,
    input  wire logic           arst_n_i,
    // link pins
    input  wire logic           serial_data_i,
    input  wire logic           serial_clk_i,
    input  wire logic           latch_i,
    // towards the control core
    serial_word_if.shifter      lnk
);

    logic [2:0]                 pin_meta;
    logic [2:0]                 pin_sync;
    logic [2:0]                 pin_prev;
    logic [CTRL_WORD_WIDTH-1:0] shift_reg;
    logic                       clk_rise;

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pin_meta <= SERIAL_SYNC_RESET;
            pin_sync <= SERIAL_SYNC_RESET;
        end
        else
        begin
            pin_meta <= {latch_i, serial_clk_i, serial_data_i};
            pin_sync <= pin_meta;
        end
    end

    // previous sample for edge finding
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            pin_prev <= SERIAL_SYNC_RESET;
        else
            pin_prev <= pin_sync;
    end

    assign clk_rise = pin_sync[1] & ~pin_prev[1];

    ////////////////////////////////////////////////////////////////////////
    // data and clock share the same delay, so the sample matches the edge
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            shift_reg <= CTRL_WORD_RESET;
        else if (clk_rise)
            shift_reg <= {shift_reg[CTRL_WORD_WIDTH-2:0], pin_sync[0]};
    end

    // latch rise marks the word complete; the core decides whether to take it
    assign lnk.latch_pulse = pin_sync[2] & ~pin_prev[2];
    assign lnk.word        = shift_reg;

endmodule

/* logic/card_power_switch_serial_control.sv */
// Top of the card power switch serial control: holds the active control
// word and decodes it into a switch setting per output.
// Assumes status pins are asynchronous and the host keeps its side.
`timescale 1ns/1ps

module card_power_switch_serial_control
    import card_power_pkg::*;
#(
    parameter int unsigned STANDBY_N_OC_HOLD = STANDBY_N_OC_CYCLES
)
(
    // clock and power-on reset
    input  wire logic    sys_clk_i,
    input  wire logic    arst_n_i,
    // serial link from the host
    input  wire logic    serial_data_i,
    input  wire logic    serial_clk_i,
    input  wire logic    latch_i,
    // reset and mode pins
    input  wire logic    card_reset_i,
    input  wire logic    card_reset_n_i,
    input  wire logic    mode_independent_i,
    input  wire logic    standby_n_i,
    // analog status from the power stage
    input  wire logic    overcurrent_a_main_i,
    input  wire logic    overcurrent_a_prog_i,
    input  wire logic    overcurrent_b_main_i,
    input  wire logic    overcurrent_b_prog_i,
    input  wire logic    overtemp_i,
    input  wire logic    supply_5v_present_i,
    input  wire logic    supply_12v_present_i,
    // switch settings per output
    output supply_level_t slot_a_main_supply_out_o,
    output supply_level_t slot_a_program_supply_out_o,
    output supply_level_t slot_b_main_supply_out_o,
    output supply_level_t slot_b_program_supply_out_o,
    // discharge switches, high closes
    output logic         discharge_switch_a_o,
    output logic         discharge_switch_b_o,
    output logic         discharge_switch_c_o,
    output logic         discharge_switch_d_o,
    // status
    output logic         output_shutdown_select_o,
    output logic         reduced_current_limit_o,
    output logic         overcurrent_flag_n_o
);

    // wide enough for the hold
    localparam int unsigned OC_CNT_W = $clog2(STANDBY_N_OC_HOLD + 1);

    serial_word_if lnk ();

    logic [PIN_SYNC_WIDTH-1:0]  pin_meta;
    logic [PIN_SYNC_WIDTH-1:0]  pin_sync;

    logic [CTRL_WORD_WIDTH-1:0] active_word;
    logic                       grounded;

    logic                       reset_active;
    logic                       latch_taken;
    logic                       low_voltage;
    logic                       independent;
    logic                       shutdown;

    logic [OC_CNT_W-1:0]        standby_n_oc_cnt;

    supply_level_t              next_a_main;
    supply_level_t              next_a_prog;

    supply_level_t              next_b_main;
    supply_level_t              next_b_prog;

    ////////////////////////////////////////////////////////////////////////
    // decoding shared by both slots

    // main output select, 11 falls back to ground like 00
    function automatic supply_level_t decode_main(input logic hi, input logic lo);
        supply_level_t lvl;
        lvl = LVL_GND;

        unique case ({hi, lo})
            2'b01:   lvl = LVL_3V3;
            2'b10:   lvl = LVL_5V;
            default: lvl = LVL_GND;
        endcase
        return lvl;
    endfunction

    // program output select; code 01 depends on the mode pin
    function automatic supply_level_t decode_prog(
        input logic          hi,
        input logic          lo,
        input logic          level_sel,
        input logic          indep,
        input supply_level_t main_lvl
    );
        supply_level_t lvl;
        lvl = LVL_GND;

        unique case ({hi, lo})
            2'b00: lvl = LVL_GND;
            2'b01: lvl = indep ? (level_sel ? LVL_5V : LVL_3V3) : main_lvl;
            2'b10: lvl = LVL_12V;
            2'b11: lvl = LVL_HIZ;
        endcase
        return lvl;
    endfunction

    // without 5 V and 12 V the stage can only pass the 3.3 V input
    function automatic supply_level_t limit_level(input supply_level_t lvl, input logic lv);
        supply_level_t res;
        res = lvl;

        if (lv && (lvl == LVL_5V || lvl == LVL_12V))
            res = LVL_3V3;
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // serial receiver
    serial_word_shifter u_shifter
    (
        .sys_clk_i     (sys_clk_i),
        .arst_n_i      (arst_n_i),
        .serial_data_i (serial_data_i),
        .serial_clk_i  (serial_clk_i),
        .latch_i       (latch_i),
        .lnk           (lnk.shifter)
    );

    ////////////////////////////////////////////////////////////////////////
    // all slow pins pass two flip-flops before anything reads them
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pin_meta <= PIN_SYNC_RESET;
            pin_sync <= PIN_SYNC_RESET;
        end
        else
        begin
            pin_meta <= {supply_12v_present_i, supply_5v_present_i, overtemp_i,
                         overcurrent_b_prog_i, overcurrent_b_main_i,
                         overcurrent_a_prog_i, overcurrent_a_main_i,
                         standby_n_i, mode_independent_i, card_reset_n_i, card_reset_i};
            pin_sync <= pin_meta;
        end
    end

    // either polarity of reset pin counts
    assign reset_active = pin_sync[PIN_RESET_HI] | ~pin_sync[PIN_RESET_N];
    assign independent  = pin_sync[PIN_MODE];
    assign low_voltage  = ~pin_sync[PIN_SUPPLY_5V] & ~pin_sync[PIN_SUPPLY_12V];

    // latch edges seen during reset are dropped, not deferred
    assign latch_taken  = lnk.latch_pulse & ~reset_active;

    ////////////////////////////////////////////////////////////////////////
    // grounded state: set at power-up and by either reset pin
    // reset outranks a latch in the same cycle
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            grounded <= 1'b1;
        else if (reset_active)
            grounded <= 1'b1;
        else if (latch_taken)
            grounded <= 1'b0;
    end

    // active word changes only on an accepted latch, never while shifting
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            active_word <= CTRL_WORD_RESET;
        else if (latch_taken)
            active_word <= lnk.word;
    end

    ////////////////////////////////////////////////////////////////////////
    // decode of the active word; shutdown bit low means all outputs high-Z unless grounded
    assign shutdown = ~active_word[SHUTDOWN_BIT_POS];

    always_comb
    begin
        next_a_main = decode_main(active_word[SLOT_A_MAIN_SEL_HI_POS],
                                  active_word[SLOT_A_MAIN_SEL_LO_POS]);
        next_b_main = decode_main(active_word[SLOT_B_MAIN_SEL_HI_POS],
                                  active_word[SLOT_B_MAIN_SEL_LO_POS]);

        next_a_prog = decode_prog(active_word[SLOT_A_PROG_SEL_HI_POS],
                                  active_word[SLOT_A_PROG_SEL_LO_POS],
                                  active_word[SLOT_A_PROG_LEVEL_POS],
                                  independent, next_a_main);

        next_b_prog = decode_prog(active_word[SLOT_B_PROG_SEL_HI_POS],
                                  active_word[SLOT_B_PROG_SEL_LO_POS],
                                  active_word[SLOT_B_PROG_LEVEL_POS],
                                  independent, next_b_main);

        next_a_main = limit_level(next_a_main, low_voltage);
        next_b_main = limit_level(next_b_main, low_voltage);

        next_a_prog = limit_level(next_a_prog, low_voltage);
        next_b_prog = limit_level(next_b_prog, low_voltage);

        // overrides come last
        if (grounded)
        begin
            // only the discharge paths conduct
            next_a_main = LVL_GND;
            next_b_main = LVL_GND;
            next_a_prog = LVL_GND;
            next_b_prog = LVL_GND;
        end
        else if (shutdown)
        begin
            next_a_main = LVL_HIZ;
            next_b_main = LVL_HIZ;
            next_a_prog = LVL_HIZ;
            next_b_prog = LVL_HIZ;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered switch settings
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            slot_a_main_supply_out_o    <= LVL_GND;
            slot_a_program_supply_out_o <= LVL_GND;
            slot_b_main_supply_out_o    <= LVL_GND;
            slot_b_program_supply_out_o <= LVL_GND;
        end
        else
        begin
            slot_a_main_supply_out_o    <= next_a_main;
            slot_a_program_supply_out_o <= next_a_prog;
            slot_b_main_supply_out_o    <= next_b_main;
            slot_b_program_supply_out_o <= next_b_prog;
        end
    end

    // a 0 V output is pulled down; in the grounded state all four close
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            discharge_switch_a_o <= 1'b1;
            discharge_switch_b_o <= 1'b1;
            discharge_switch_c_o <= 1'b1;
            discharge_switch_d_o <= 1'b1;
        end
        else
        begin
            discharge_switch_a_o <= (next_a_main == LVL_GND);
            discharge_switch_b_o <= (next_a_prog == LVL_GND);
            discharge_switch_c_o <= (next_b_main == LVL_GND);
            discharge_switch_d_o <= (next_b_prog == LVL_GND);
        end
    end

    // shutdown status and standby current limit
    // shutdown is hidden while grounded
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            output_shutdown_select_o <= 1'b0;
            reduced_current_limit_o  <= 1'b0;
        end
        else
        begin
            output_shutdown_select_o <= shutdown & ~grounded;
            reduced_current_limit_o  <= ~pin_sync[PIN_STANDBY_N];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // a new setting under the 50 mA limit trips the limiter for a while;
    // modelled as a fixed hold since the real cause is analog inrush
    // restarts on each new word
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            standby_n_oc_cnt <= '0;
        else if (latch_taken && !pin_sync[PIN_STANDBY_N] && lnk.word != active_word)
            standby_n_oc_cnt <= OC_CNT_W'(STANDBY_N_OC_HOLD);
        else if (standby_n_oc_cnt != '0)
            standby_n_oc_cnt <= standby_n_oc_cnt - 1'b1;
    end

    // any output overcurrent or overtemperature pulls the flag low
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            overcurrent_flag_n_o <= 1'b1;
        else
            overcurrent_flag_n_o <= ~(pin_sync[PIN_OC_A_MAIN] | pin_sync[PIN_OC_A_PROG] |
                                      pin_sync[PIN_OC_B_MAIN] | pin_sync[PIN_OC_B_PROG] |
                                      pin_sync[PIN_OVERTEMP]  | (standby_n_oc_cnt != '0));
    end

endmodule

/* dv/card_power_asserts.sv */
// Checker bound to the top of the card power switch serial control.
// Assumes pins are held for several cycles.
`timescale 1ns/1ps

module card_power_asserts
    import card_power_pkg::*;
(
    // clock, reset and pins
    input wire logic       sys_clk_i,
    input wire logic       arst_n_i,
    input wire logic       latch_i,
    input wire logic       card_reset_i,
    input wire logic       card_reset_n_i,
    input wire logic       standby_n_i,
    input wire logic       overcurrent_a_main_i,
    input wire logic       overtemp_i,
    input wire logic       supply_5v_present_i,
    // outputs
    input wire logic [2:0] slot_a_main_supply_out_o,
    input wire logic [2:0] slot_a_program_supply_out_o,
    input wire logic [2:0] slot_b_main_supply_out_o,
    input wire logic [2:0] slot_b_program_supply_out_o,
    input wire logic       discharge_switch_a_o,
    input wire logic       discharge_switch_d_o,
    input wire logic       output_shutdown_select_o,
    input wire logic       reduced_current_limit_o,
    input wire logic       overcurrent_flag_n_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    ////////////////////////////////////////////////////////////////////////
    // the four level outputs side by side
    wire logic [11:0] lvls    = {slot_a_main_supply_out_o, slot_a_program_supply_out_o,
                                 slot_b_main_supply_out_o, slot_b_program_supply_out_o};
    wire logic        all_gnd = lvls == {4{LVL_GND}};
    wire logic        all_hiz = lvls == {4{LVL_HIZ}};

    ////////////////////////////////////////////////////////////////////////
    // pin resets ground all within four edges
    chk_reset_hi_ground:
        assert property (card_reset_i [*5] |-> all_gnd && discharge_switch_a_o)
        else $error("high reset not grounding");
    chk_reset_lo_ground:
        assert property (!card_reset_n_i [*5] |-> all_gnd && discharge_switch_d_o)
        else $error("low reset not grounding");
    chk_discharge_map:
        assert property (discharge_switch_a_o == (slot_a_main_supply_out_o == LVL_GND))
        else $error("discharge a mismatch");
    chk_shutdown_hiz:
        assert property (output_shutdown_select_o |-> all_hiz)
        else $error("shutdown output driven");
    chk_standby_limit:
        assert property (!standby_n_i [*4] |-> reduced_current_limit_o)
        else $error("standby limit missing");
    chk_standby_release:
        assert property (standby_n_i [*4] |-> !reduced_current_limit_o)
        else $error("limit without standby");
    chk_oc_flag:
        assert property (overcurrent_a_main_i [*4] |-> !overcurrent_flag_n_o)
        else $error("overcurrent not flagged");
    chk_overtemp_flag:
        assert property (overtemp_i [*4] |-> !overcurrent_flag_n_o)
        else $error("overtemp not flagged");
    // quiet latch pin: main level holds
    chk_word_hold:
        assert property ((!latch_i && !card_reset_i && card_reset_n_i
            && supply_5v_present_i) [*8] |=> $stable(slot_a_main_supply_out_o))
        else $error("a main moved unlatched");
endmodule

bind card_power_switch_serial_control card_power_asserts i_card_power_asserts
(
    .sys_clk_i, .arst_n_i, .latch_i, .card_reset_i, .card_reset_n_i, .standby_n_i,
    .overcurrent_a_main_i, .overtemp_i, .supply_5v_present_i, .slot_a_main_supply_out_o,
    .slot_a_program_supply_out_o, .slot_b_main_supply_out_o, .slot_b_program_supply_out_o,
    .discharge_switch_a_o, .discharge_switch_d_o, .output_shutdown_select_o,
    .reduced_current_limit_o, .overcurrent_flag_n_o
);

/* dv/host_serial_model.sv */
// Host side of the serial link: shifts words out top bit first.
// Assumes a 100 MHz system clock; link clock half period 80 ns.
`timescale 1ns/1ps

module host_serial_model
(
    // clock
    input  wire logic sys_clk_i,
    // link pins, idle with clock and latch low
    output logic      serial_data_o = 1'b0,
    output logic      serial_clk_o  = 1'b0,
    output logic      latch_o       = 1'b0
);
    ////////////////////////////////////////////////////////////////////////////////
    // one link half period; pins only move on falling system edges
    task automatic half_period();
        repeat (8) @(negedge sys_clk_i);
    endtask

    // first bit sent lands in the top position
    task automatic send_word(input logic [10:0] w, input logic do_latch);
        for (int i = 10; i >= 0; i--)
        begin
            serial_data_o = w[i];
            half_period();
            serial_clk_o = 1'b1;
            half_period();
            serial_clk_o = 1'b0;
        end
        serial_data_o = ~serial_data_o; // stale bit must not look valid
        if (do_latch)
        begin
            half_period();
            latch_o = 1'b1;
            half_period();
            latch_o = 1'b0;
        end
        half_period();
    endtask
endmodule

/* dv/card_power_switch_serial_control_test.sv */
// Self-checking bench for the card power switch serial control.
// Assumes the host model drives the link; other pins are set here.
`timescale 1ns/1ps

module card_power_switch_serial_control_test;
    import card_power_pkg::*;

    localparam int unsigned HOLD = 4;
    localparam logic [10:0] WORDS [5] = '{11'h566, 11'h1B9, 11'h1CC, 11'h722, 11'h0B9};

    logic sys_clk_i = 1'b0, arst_n_i = 1'b0, card_reset_i = 1'b0, card_reset_n_i = 1'b1;
    logic mode_independent_i = 1'b1, standby_n_i = 1'b1, seen = 1'b0;
    logic supply_5v_present_i = 1'b1, supply_12v_present_i = 1'b1;
    logic [4:0] fault = 5'h00;
    logic serial_data_i, serial_clk_i, latch_i;
    supply_level_t slot_a_main_supply_out_o, slot_a_program_supply_out_o;
    supply_level_t slot_b_main_supply_out_o, slot_b_program_supply_out_o;
    logic discharge_switch_a_o, discharge_switch_b_o, discharge_switch_c_o;
    logic discharge_switch_d_o, output_shutdown_select_o, reduced_current_limit_o;
    logic overcurrent_flag_n_o;
    int   n_fail = 0;
    int   checks_done = 0;
    wire logic [3:0] dis = {discharge_switch_d_o, discharge_switch_c_o,
                            discharge_switch_b_o, discharge_switch_a_o};
    wire supply_level_t outs [4] = '{slot_a_main_supply_out_o, slot_a_program_supply_out_o,
                                     slot_b_main_supply_out_o, slot_b_program_supply_out_o};

    always #5 sys_clk_i = ~sys_clk_i;

    host_serial_model i_host_serial_model
    (
        .sys_clk_i(sys_clk_i), .serial_data_o(serial_data_i),
        .serial_clk_o(serial_clk_i), .latch_o(latch_i)
    );

    card_power_switch_serial_control #(.STANDBY_N_OC_HOLD(HOLD)) i_card_power_switch_serial_control
    (
        .sys_clk_i, .arst_n_i, .serial_data_i, .serial_clk_i, .latch_i, .card_reset_i,
        .card_reset_n_i, .mode_independent_i, .standby_n_i,
        .overcurrent_a_main_i(fault[0]), .overcurrent_a_prog_i(fault[1]),
        .overcurrent_b_main_i(fault[2]), .overcurrent_b_prog_i(fault[3]),
        .overtemp_i(fault[4]), .supply_5v_present_i, .supply_12v_present_i,
        .slot_a_main_supply_out_o, .slot_a_program_supply_out_o, .slot_b_main_supply_out_o,
        .slot_b_program_supply_out_o, .discharge_switch_a_o, .discharge_switch_b_o,
        .discharge_switch_c_o, .discharge_switch_d_o, .output_shutdown_select_o,
        .reduced_current_limit_o, .overcurrent_flag_n_o
    );

    ////////////////////////////////////////////////////////////////////////////////
    // comparisons and the closing report
    task automatic check_lvl(input string what, input supply_level_t e, input supply_level_t g);
        checks_done++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %0d seen %0d", what, e, g);
        end
    endtask

    task automatic check_bits(input string what, input logic [3:0] e, input logic [3:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // expected levels; 3.3 V only without 5 V and 12 V
    function automatic supply_level_t lim(supply_level_t l);
        return (!supply_5v_present_i && !supply_12v_present_i && l inside {LVL_5V, LVL_12V})
            ? LVL_3V3 : l;
    endfunction

    function automatic supply_level_t main_exp(logic hi, logic lo);
        return lim({hi, lo} == 2'b01 ? LVL_3V3 : {hi, lo} == 2'b10 ? LVL_5V : LVL_GND);
    endfunction

    function automatic supply_level_t prog_exp(logic hi, logic lo, logic lvl, supply_level_t m);
        case ({hi, lo})
            2'b00:   return LVL_GND;
            2'b10:   return lim(LVL_12V);
            2'b11:   return LVL_HIZ;
            default: return mode_independent_i ? lim(lvl ? LVL_5V : LVL_3V3) : m;
        endcase
    endfunction

    task automatic check_word(input logic [10:0] w);
        supply_level_t lv [4];
        lv[0] = main_exp(w[3], w[2]);
        lv[2] = main_exp(w[6], w[7]);
        lv[1] = prog_exp(w[0], w[1], w[9], lv[0]);
        lv[3] = prog_exp(w[4], w[5], w[10], lv[2]);
        if (!w[8])
            lv = '{default: LVL_HIZ};
        foreach (lv[i])
            check_lvl("level", lv[i], outs[i]);
        check_bits("discharge", {lv[3] == LVL_GND, lv[2] == LVL_GND, lv[1] == LVL_GND,
                   lv[0] == LVL_GND}, dis);
        check_bits("shutdown", {3'h0, !w[8]}, {3'h0, output_shutdown_select_o});
    endtask

    task automatic check_ground();
        foreach (outs[i])
            check_lvl("level", LVL_GND, outs[i]);
        check_bits("discharge", 4'hF, dis);
    endtask

    task automatic send(input logic [10:0] w, input logic do_latch);
        i_host_serial_model.send_word(w, do_latch);
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        tick(3);
        arst_n_i = 1'b1;
        tick(1);
        check_ground();
        check_bits("status", 4'h1, {1'b0, output_shutdown_select_o, reduced_current_limit_o,
                   overcurrent_flag_n_o});
        $display("test power_on done");
        for (int m = 1; m >= 0; m--)
        begin
            mode_independent_i = m[0];
            foreach (WORDS[i])
            begin
                send(WORDS[i], 1'b1);
                check_word(WORDS[i]);
            end
        end
        send(11'h566, 1'b0);
        check_word(11'h0B9);
        send(11'h566, 1'b1);
        check_word(11'h566);
        $display("test decode done");
        {supply_5v_present_i, supply_12v_present_i} = 2'b00;
        send(11'h1B9, 1'b1);
        check_word(11'h1B9);
        {supply_5v_present_i, supply_12v_present_i} = 2'b11;
        tick(6);
        check_word(11'h1B9);
        $display("test low_voltage done");
        for (int k = 0; k < 2; k++)
        begin
            card_reset_i   = (k == 0);
            card_reset_n_i = (k == 0);
            tick(6);
            check_ground();
            send(11'h722, 1'b1);
            check_ground();
            card_reset_i   = 1'b0;
            card_reset_n_i = 1'b1;
            tick(6);
            check_ground();
            send(11'h722, 1'b1);
            check_word(11'h722);
        end
        $display("test reset done");
        standby_n_i = 1'b0;
        tick(4);
        check_bits("reduced", 4'h1, {3'h0, reduced_current_limit_o});
        // short flag pulse: watch it while the word goes out
        fork
            send(11'h566, 1'b1);
            repeat (400)
            begin
                @(negedge sys_clk_i);
                seen = seen | !overcurrent_flag_n_o;
            end
        join
        check_bits("oc_standby", 4'h1, {3'h0, seen});
        check_word(11'h566);
        standby_n_i = 1'b1;
        tick(4);
        check_bits("reduced", 4'h0, {3'h0, reduced_current_limit_o});
        $display("test standby done");
        for (int i = 0; i < 5; i++)
        begin
            fault = 5'h01 << i;
            tick(4);
            check_bits("flag_n", 4'h0, {3'h0, overcurrent_flag_n_o});
            fault = 5'h00;
            tick(4);
            check_bits("flag_n", 4'h1, {3'h0, overcurrent_flag_n_o});
        end
        $display("test overcurrent done");
        summarize();
    end

    // hang guard
    initial
    begin
        repeat (100000) @(posedge sys_clk_i);
        n_fail++;
        summarize();
    end
endmodule
